/* File: hw/tmw_consts.svh */
// Constants of the 16-bit timer mode-control block: register indices, field ranges, codes and fixed TOP values.
// Assumes a 32-bit classic Wishbone bus; each register index is a word, byte address is four times the index.
`ifndef TMW_CONSTS_SVH
`define TMW_CONSTS_SVH
// Register word indices; the byte address is the index shifted left by two.
`define TMW_IDX_CTRL_A 10'h080
`define TMW_IDX_CTRL_B 10'h081
`define TMW_IDX_CMP_A 10'h088
`define TMW_IDX_CMP_B 10'h089
`define TMW_IDX_CAPT 10'h08a
`define TMW_IDX_CNT 10'h08b
`define TMW_IDX_FLAGS 10'h08c
// Implemented bits of the two control registers and their reset value.
`define TMW_CTRL_A_MASK 8'hf3
`define TMW_CTRL_B_MASK 8'hdf
`define TMW_CTRL_RST 8'h00
// Field ranges inside the control registers.
`define TMW_A_COMA 7:6
`define TMW_A_COMB 5:4
`define TMW_A_RSVD 3:2
`define TMW_A_WGML 1:0
`define TMW_B_NC 7
`define TMW_B_ES 6
`define TMW_B_WGMH 4:3
`define TMW_B_CS 2:0
// Flag bit positions; software clears a flag by writing a one.
`define TMW_F_OVF 0
`define TMW_F_MA 1
`define TMW_F_MB 2
`define TMW_F_CAP 3
// Compare output mode codes.
`define TMW_COM_OFF 2'h0
`define TMW_COM_TGL 2'h1
`define TMW_COM_CLR 2'h2
`define TMW_COM_SET 2'h3
// Waveform generation mode codes.
`define TMW_WGM_NORMAL 4'h0
`define TMW_WGM_PC8 4'h1
`define TMW_WGM_PC9 4'h2
`define TMW_WGM_PC10 4'h3
`define TMW_WGM_CTC_OCR 4'h4
`define TMW_WGM_FAST8 4'h5
`define TMW_WGM_FAST9 4'h6
`define TMW_WGM_FAST10 4'h7
`define TMW_WGM_PFC_ICR 4'h8
`define TMW_WGM_PFC_OCR 4'h9
`define TMW_WGM_PC_ICR 4'ha
`define TMW_WGM_PC_OCR 4'hb
`define TMW_WGM_CTC_ICR 4'hc
`define TMW_WGM_RSVD 4'hd
`define TMW_WGM_FAST_ICR 4'he
`define TMW_WGM_FAST_OCR 4'hf
// Clock select codes and prescaler terminal masks.
`define TMW_CS_STOP 3'h0
`define TMW_CS_DIV1 3'h1
`define TMW_CS_DIV8 3'h2
`define TMW_CS_DIV64 3'h3
`define TMW_CS_DIV256 3'h4
`define TMW_CS_DIV1024 3'h5
`define TMW_CS_EXT_FALL 3'h6
`define TMW_CS_EXT_RISE 3'h7
`define TMW_PRE_8 10'h007
`define TMW_PRE_64 10'h03f
`define TMW_PRE_256 10'h0ff
`define TMW_PRE_1024 10'h3ff
// Counter extremes and fixed TOP values.
`define TMW_BOTTOM 16'h0000
`define TMW_TOP_MAX 16'hffff
`define TMW_TOP_8 16'h00ff
`define TMW_TOP_9 16'h01ff
`define TMW_TOP_10 16'h03ff
// Successive equal samples the capture noise filter needs.
`define TMW_NC_SAMPLES 4
`endif

/* File: hw/tmw_pkg.sv */
// Types shared by the timer mode-control block.
// Assumes tmw_consts.svh supplies all numeric constants.
package tmw_pkg;
  // Waveform class decoded from the waveform generation mode.
  typedef enum logic [1:0] {TMW_NONPWM, TMW_FAST, TMW_DUAL} tmw_class_t;
endpackage : tmw_pkg

/* File: hw/tmw_noise_filter.sv */
// Capture-input noise filter: output follows the input only after a run of equal samples.
// Assumes the input is already synchronised to clk_i.
`timescale 1ns/1ps
`include "tmw_consts.svh"
module tmw_noise_filter #(
  parameter int SAMPLES = `TMW_NC_SAMPLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Control and data.
  input wire logic en_i,
  input wire logic pin_i,
  output logic filt_o
);
  logic [SAMPLES-1:0] hist_reg; // Last samples, newest in bit zero.
  logic filt_reg; // Filtered level.
  logic filt_next;
  wire all_hi = &hist_reg;
  wire all_lo = ~|hist_reg;

  // Disabled, the filter is a single register stage; enabled, it waits for a full run.
  assign filt_next = !en_i ? pin_i : all_hi ? 1'b1 : all_lo ? 1'b0 : filt_reg; // R15
  assign filt_o = filt_reg;

  // History and output registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hist_reg <= '0;
      filt_reg <= 1'b0;
    end else begin
      hist_reg <= {hist_reg[SAMPLES-2:0], pin_i};
      filt_reg <= filt_next;
    end
  end

  // A mixed history must never move the enabled filter's output.
  property p_nc_hold;
    @(posedge clk_i) disable iff (rst_i) (en_i && !all_hi && !all_lo) |=> $stable(filt_reg);
  endproperty
  a_nc_hold: assert property (p_nc_hold) else $error("filter output moved on mixed samples"); // R15
endmodule : tmw_noise_filter

/* File: hw/tmw_timer.sv */
// 16-bit timer with waveform mode decoding, two compare outputs and filtered input capture.
// Assumes a classic Wishbone master on clk_i and pins that are asynchronous to clk_i.
`timescale 1ns/1ps
`include "tmw_consts.svh"
// Functional notes
// R1: Counter synchronous; tick acts as clock enable.
// R2: Nonzero output mode takes pin when direction=output.
// R3: Non-PWM: off, toggle, clear, set on match.
// R4: Fast PWM toggle only channel A, modes 14/15.
// R5: Fast PWM: clear/set on match, opposite at BOTTOM.
// R6: Fast PWM compare equal TOP: only BOTTOM action.
// R7: Dual-slope toggle only channel A, modes 9/11.
// R8: Dual-slope: match action depends on count direction.
// R9: Mode is four bits split over registers.
// R10: Normal: TOP 0xFFFF, immediate update, overflow MAX.
// R11: Phase correct: TOP fixed/capture/A, update TOP.
// R12: Fast PWM: TOP fixed/capture/A, update BOTTOM.
// R13: Clear-on-match: TOP A or capture, MAX flag.
// R14: Phase-frequency correct: update and overflow at BOTTOM.
// R15: Filter needs four equal samples before changing.
// R16: Clock select: stop, prescaled, external edges.
// R17: Capture on selected edge, copies counter, flags.
// R18: Capture disabled when capture register is TOP.
// R19: Software must not use reserved mode 13.
// R20: Unused control bits read zero, ignore writes.
module tmw_timer (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins and port direction bits.
  input wire logic ext_clk_pin_i,
  input wire logic capture_pin_i,
  input wire logic dir_a_i,
  input wire logic dir_b_i,
  output logic wave_out_a_o,
  output logic wave_out_a_oe_o,
  output logic wave_out_b_o,
  output logic wave_out_b_oe_o
);
  // Software-visible state.
  logic [7:0] ctrl_a_reg, ctrl_b_reg; // Control registers A and B.
  logic [15:0] cmp_a_buf_reg, cmp_b_buf_reg; // Compare buffers written by software.
  logic [15:0] cmp_a_reg, cmp_b_reg; // Compare values in use.
  logic [15:0] cap_reg; // Capture value.
  logic [15:0] cnt_reg, cnt_next; // Counter value.
  logic dir_reg, dir_next; // High while a dual-slope count runs down.
  logic [3:0] flags_reg; // Sticky event flags.
  // Clocking and pin state.
  logic [9:0] pre_reg; // Free-running prescaler.
  logic t1_s1_reg, t1_s2_reg, t1_s3_reg; // External clock synchroniser and edge stage.
  logic icp_s1_reg, icp_s2_reg; // Capture pin synchroniser.
  logic filt_d_reg; // Delayed filtered capture level for edge detection.
  logic wave_a_reg, wave_b_reg, oe_a_reg, oe_b_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic filt;
  logic tick;
  // Mode decoding.
  wire [3:0] wgm = {ctrl_b_reg[`TMW_B_WGMH], ctrl_a_reg[`TMW_A_WGML]}; // R9
  wire [2:0] cs = ctrl_b_reg[`TMW_B_CS];
  wire [1:0] com_a = ctrl_a_reg[`TMW_A_COMA];
  wire [1:0] com_b = ctrl_a_reg[`TMW_A_COMB];
  // Class of a waveform mode; the reserved code falls in with the plain counters.
  function automatic tmw_pkg::tmw_class_t class_of(input logic [3:0] w);
    case (w)
      `TMW_WGM_FAST8, `TMW_WGM_FAST9, `TMW_WGM_FAST10,
      `TMW_WGM_FAST_ICR, `TMW_WGM_FAST_OCR: class_of = tmw_pkg::TMW_FAST;
      `TMW_WGM_NORMAL, `TMW_WGM_CTC_OCR, `TMW_WGM_CTC_ICR, `TMW_WGM_RSVD: class_of = tmw_pkg::TMW_NONPWM; // R19
      default: class_of = tmw_pkg::TMW_DUAL;
    endcase
  endfunction : class_of
  // High when the mode takes TOP from the capture register.
  function automatic logic cap_is_top(input logic [3:0] w);
    cap_is_top = (w == `TMW_WGM_PFC_ICR) || (w == `TMW_WGM_PC_ICR) ||
                 (w == `TMW_WGM_CTC_ICR) || (w == `TMW_WGM_FAST_ICR);
  endfunction : cap_is_top
  // TOP of each mode.
  function automatic logic [15:0] top_of(input logic [3:0] w, input logic [15:0] ocr, input logic [15:0] icr);
    case (w)
      `TMW_WGM_PC8, `TMW_WGM_FAST8: top_of = `TMW_TOP_8; // R11 R12
      `TMW_WGM_PC9, `TMW_WGM_FAST9: top_of = `TMW_TOP_9;
      `TMW_WGM_PC10, `TMW_WGM_FAST10: top_of = `TMW_TOP_10;
      `TMW_WGM_CTC_OCR, `TMW_WGM_PFC_OCR, `TMW_WGM_PC_OCR, `TMW_WGM_FAST_OCR: top_of = ocr; // R13 R14
      `TMW_WGM_PFC_ICR, `TMW_WGM_PC_ICR, `TMW_WGM_CTC_ICR, `TMW_WGM_FAST_ICR: top_of = icr;
      default: top_of = `TMW_TOP_MAX; // R10
    endcase
  endfunction : top_of
  // Byte-lane merge of a 16-bit register write.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16
  // One channel's output: returns {connected, next level}. Hit already carries the tick.
  function automatic logic [1:0] chan_f(input tmw_pkg::tmw_class_t c, input logic [3:0] w, input logic [1:0] com,
                                        input logic is_a, input logic cur, input logic hit, input logic wrap,
                                        input logic down, input logic hit_top);
    logic conn;
    logic nxt;
    conn = (com != `TMW_COM_OFF); // R2
    nxt = cur;
    case (c)
      tmw_pkg::TMW_FAST: begin
        if (com == `TMW_COM_TGL) begin
          conn = is_a && (w == `TMW_WGM_FAST_ICR || w == `TMW_WGM_FAST_OCR); // R4
          if (conn && hit) nxt = ~cur;
        end else if (com != `TMW_COM_OFF) begin
          // The wrap to BOTTOM outranks a match, so a compare at TOP only gives the BOTTOM action.
          if (wrap) nxt = (com == `TMW_COM_CLR); // R5 R6
          else if (hit && !hit_top) nxt = (com == `TMW_COM_SET); // R5
        end
      end
      tmw_pkg::TMW_DUAL: begin
        if (com == `TMW_COM_TGL) begin
          conn = is_a && (w == `TMW_WGM_PFC_OCR || w == `TMW_WGM_PC_OCR); // R7
          if (conn && hit) nxt = ~cur;
        end else if (com != `TMW_COM_OFF && hit) begin
          nxt = (com == `TMW_COM_CLR) ? down : ~down; // R8
        end
      end
      default: begin
        if (hit) begin
          case (com)
            `TMW_COM_TGL: nxt = ~cur; // R3
            `TMW_COM_CLR: nxt = 1'b0;
            `TMW_COM_SET: nxt = 1'b1;
            default: nxt = cur;
          endcase
        end
      end
    endcase
    chan_f = {conn, nxt};
  endfunction : chan_f
  // Counter status.
  wire tmw_pkg::tmw_class_t cls = class_of(wgm);
  wire [15:0] top = top_of(wgm, cmp_a_reg, cap_reg);
  wire at_top = (cnt_reg == top);
  wire at_bottom = (cnt_reg == `TMW_BOTTOM);
  wire cap_top = cap_is_top(wgm);
  wire pfc = (wgm == `TMW_WGM_PFC_ICR) || (wgm == `TMW_WGM_PFC_OCR);
  wire hit_a = tick && (cnt_reg == cmp_a_reg);
  wire hit_b = tick && (cnt_reg == cmp_b_reg);
  wire wrap = tick && at_top && (cls == tmw_pkg::TMW_FAST);
  // Bus decode; a write lands on the edge at which the master sees ack.
  wire bus_req = wb_cyc_i && wb_stb_i;
  wire wr_go = bus_req && wb_we_i && ack_reg;
  wire [9:0] idx = wb_adr_i[11:2];
  wire hit_ca = (idx == `TMW_IDX_CTRL_A);
  wire hit_cb = (idx == `TMW_IDX_CTRL_B);
  wire wr_cnt = wr_go && (idx == `TMW_IDX_CNT);
  wire wr_cap = wr_go && (idx == `TMW_IDX_CAPT);
  wire [3:0] flag_clr = (wr_go && idx == `TMW_IDX_FLAGS && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;
  wire [31:0] rd_data = hit_ca ? {24'h000000, ctrl_a_reg} : hit_cb ? {24'h000000, ctrl_b_reg} :
                        (idx == `TMW_IDX_CMP_A) ? {16'h0000, cmp_a_buf_reg} :
                        (idx == `TMW_IDX_CMP_B) ? {16'h0000, cmp_b_buf_reg} :
                        (idx == `TMW_IDX_CAPT) ? {16'h0000, cap_reg} :
                        (idx == `TMW_IDX_CNT) ? {16'h0000, cnt_reg} :
                        (idx == `TMW_IDX_FLAGS) ? {28'h0000000, flags_reg} : 32'h00000000;
  // Timer tick: a one-cycle enable, never a clock of its own.
  always_comb begin
    case (cs) // R16
      `TMW_CS_DIV1: tick = 1'b1;
      `TMW_CS_DIV8: tick = ((pre_reg & `TMW_PRE_8) == `TMW_PRE_8);
      `TMW_CS_DIV64: tick = ((pre_reg & `TMW_PRE_64) == `TMW_PRE_64);
      `TMW_CS_DIV256: tick = ((pre_reg & `TMW_PRE_256) == `TMW_PRE_256);
      `TMW_CS_DIV1024: tick = (pre_reg == `TMW_PRE_1024);
      `TMW_CS_EXT_FALL: tick = t1_s3_reg && !t1_s2_reg;
      `TMW_CS_EXT_RISE: tick = !t1_s3_reg && t1_s2_reg;
      default: tick = 1'b0;
    endcase
  end
  // Counting sequence; a software write to the counter wins over a tick.
  always_comb begin
    cnt_next = cnt_reg;
    dir_next = 1'b0;
    if (cls == tmw_pkg::TMW_DUAL) begin
      dir_next = dir_reg;
      if (tick && at_top) dir_next = 1'b1; // R11 R14
      else if (tick && at_bottom) dir_next = 1'b0;
      if (tick) cnt_next = dir_next ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001; // R1
    end else if (tick) begin
      cnt_next = at_top ? `TMW_BOTTOM : cnt_reg + 16'h0001; // R10 R12 R13
    end
    if (wr_cnt) cnt_next = merge16(cnt_reg, wb_dat_i, wb_sel_i);
  end
  // Compare load: immediate for plain counters, at TOP for phase correct, at BOTTOM otherwise.
  wire upd_cmp = (cls == tmw_pkg::TMW_NONPWM) || // R10 R13
                 (tick && ((cls == tmw_pkg::TMW_DUAL && !pfc) ? at_top : at_bottom)); // R11 R12 R14
  // Overflow moment per class.
  wire ovf_ev = tick && ((cls == tmw_pkg::TMW_NONPWM) ? (cnt_reg == `TMW_TOP_MAX) : // R10 R13
                         (cls == tmw_pkg::TMW_FAST) ? at_top : at_bottom); // R11 R12 R14
  // Capture edge from the filtered pin, disabled while the capture register is TOP.
  wire cap_edge = ctrl_b_reg[`TMW_B_ES] ? (filt && !filt_d_reg) : (!filt && filt_d_reg);
  wire capt_ev = cap_edge && !cap_top; // R17 R18
  wire [3:0] flag_set = {capt_ev || (tick && at_top && cap_top), hit_b, hit_a, ovf_ev};
  wire [1:0] ch_a = chan_f(cls, wgm, com_a, 1'b1, wave_a_reg, hit_a, wrap, dir_reg, cmp_a_reg == top);
  wire [1:0] ch_b = chan_f(cls, wgm, com_b, 1'b0, wave_b_reg, hit_b, wrap, dir_reg, cmp_b_reg == top);
  // Capture filter; it sees only the second synchroniser stage.
  tmw_noise_filter #(.SAMPLES(`TMW_NC_SAMPLES)) u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(ctrl_b_reg[`TMW_B_NC]), // R15
    .pin_i(icp_s2_reg),
    .filt_o(filt)
  );
  // Pin synchronisers and prescaler.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {t1_s1_reg, t1_s2_reg, t1_s3_reg, icp_s1_reg, icp_s2_reg, filt_d_reg} <= 6'h00;
      pre_reg <= 10'h000;
    end else begin
      {t1_s1_reg, t1_s2_reg, t1_s3_reg} <= {ext_clk_pin_i, t1_s1_reg, t1_s2_reg};
      {icp_s1_reg, icp_s2_reg} <= {capture_pin_i, icp_s1_reg};
      filt_d_reg <= filt;
      pre_reg <= pre_reg + 10'h001;
    end
  end
  // Control registers; unimplemented bits never store a one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_a_reg <= `TMW_CTRL_RST;
      ctrl_b_reg <= `TMW_CTRL_RST;
    end else begin
      if (wr_go && hit_ca && wb_sel_i[0]) ctrl_a_reg <= wb_dat_i[7:0] & `TMW_CTRL_A_MASK; // R20
      if (wr_go && hit_cb && wb_sel_i[0]) ctrl_b_reg <= wb_dat_i[7:0] & `TMW_CTRL_B_MASK; // R20
    end
  end
  // Compare buffers and their double-buffered copies.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {cmp_a_buf_reg, cmp_b_buf_reg, cmp_a_reg, cmp_b_reg} <= 64'h0000000000000000;
    end else begin
      if (wr_go && idx == `TMW_IDX_CMP_A) cmp_a_buf_reg <= merge16(cmp_a_buf_reg, wb_dat_i, wb_sel_i);
      if (wr_go && idx == `TMW_IDX_CMP_B) cmp_b_buf_reg <= merge16(cmp_b_buf_reg, wb_dat_i, wb_sel_i);
      if (upd_cmp) begin
        cmp_a_reg <= cmp_a_buf_reg;
        cmp_b_reg <= cmp_b_buf_reg;
      end
    end
  end
  // Counter, direction, capture and flags; a flag set beats a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= `TMW_BOTTOM;
      dir_reg <= 1'b0;
      cap_reg <= 16'h0000;
      flags_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
      dir_reg <= dir_next;
      if (wr_cap) cap_reg <= merge16(cap_reg, wb_dat_i, wb_sel_i);
      else if (capt_ev) cap_reg <= cnt_reg; // R17
      flags_reg <= (flags_reg & ~flag_clr) | flag_set;
    end
  end
  // Waveform outputs; the driver is enabled only for a connected channel whose port is an output.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {wave_a_reg, wave_b_reg, oe_a_reg, oe_b_reg} <= 4'h0;
    end else begin
      wave_a_reg <= ch_a[0];
      wave_b_reg <= ch_b[0];
      oe_a_reg <= ch_a[1] && dir_a_i; // R2
      oe_b_reg <= ch_b[1] && dir_b_i; // R2
    end
  end
  // Bus answer one cycle after the request; unmapped words read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= bus_req && !ack_reg;
      if (bus_req && !ack_reg) dat_reg <= rd_data;
    end
  end
  // Every output comes straight from a register.
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign wave_out_a_o = wave_a_reg;
  assign wave_out_b_o = wave_b_reg;
  assign wave_out_a_oe_o = oe_a_reg;
  assign wave_out_b_oe_o = oe_b_reg;
  // Checks on the counter, outputs and bus.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_stop_hold;
    (cs == `TMW_CS_STOP && !wr_cnt) |=> $stable(cnt_reg);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("counter moved while stopped"); // R16
  property p_normal_ovf;
    (tick && wgm == `TMW_WGM_NORMAL && cnt_reg == `TMW_TOP_MAX && !wr_cnt) |=>
      (cnt_reg == `TMW_BOTTOM) && flags_reg[`TMW_F_OVF];
  endproperty
  a_normal_ovf: assert property (p_normal_ovf) else $error("normal mode overflow wrong"); // R10
  property p_ctc_clear;
    (tick && wgm == `TMW_WGM_CTC_OCR && cnt_reg == cmp_a_reg && !wr_cnt) |=> cnt_reg == `TMW_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("clear-on-match did not clear"); // R13
  property p_dual_turn;
    (tick && cls == tmw_pkg::TMW_DUAL && at_top && !at_bottom && !wr_cnt) |=>
      dir_reg && cnt_reg == $past(cnt_reg) - 16'h0001;
  endproperty
  a_dual_turn: assert property (p_dual_turn) else $error("dual slope did not turn at TOP"); // R11
  property p_fast_wrap;
    (wrap && !wr_cnt) |=> (cnt_reg == `TMW_BOTTOM) && flags_reg[`TMW_F_OVF];
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("fast PWM wrap wrong"); // R12
  property p_nonpwm_tgl;
    (hit_a && cls == tmw_pkg::TMW_NONPWM && com_a == `TMW_COM_TGL) |=> wave_a_reg != $past(wave_a_reg);
  endproperty
  a_nonpwm_tgl: assert property (p_nonpwm_tgl) else $error("no toggle on match"); // R3
  property p_fast_bottom;
    (wrap && com_a == `TMW_COM_CLR) |=> wave_a_reg;
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("fast PWM not set at BOTTOM"); // R5
  property p_oe_off;
    (com_a == `TMW_COM_OFF) |=> !wave_out_a_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven while disconnected"); // R2
  property p_cap_off;
    (cap_top && !wr_cap) |=> $stable(cap_reg);
  endproperty
  a_cap_off: assert property (p_cap_off) else $error("capture while capture is TOP"); // R18
  property p_rsvd_zero;
    (bus_req && !ack_reg && hit_ca) |=> wb_ack_o && wb_dat_o[`TMW_A_RSVD] == 2'b00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero"); // R20
  c_fast_wrap: cover property (wrap && com_a == `TMW_COM_CLR);
  c_dual_turn: cover property (tick && cls == tmw_pkg::TMW_DUAL && at_top);
  c_capture: cover property (capt_ev);
endmodule : tmw_timer

/* File: tb/tb_top.sv */
// Self-checking bench for the timer mode-control block: registers, waveform modes and capture filter.
// Assumes the design's Wishbone slave acks one cycle after a request and ticks every cycle at divide-by-one.
`timescale 1ns/1ps
module tb_top;
  logic clk_i, rst_i, cyc, stb, we, ext_pin, cap_pin, dir_a, dir_b;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rd, q;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, wa, wa_oe, wb_o, wb_oe;
  int num_errors, n_checks, hi;
  // Device under test; every input is driven by the bench.
  tmw_timer u_tmw_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_clk_pin_i(ext_pin), .capture_pin_i(cap_pin), .dir_a_i(dir_a), .dir_b_i(dir_b),
    .wave_out_a_o(wa), .wave_out_a_oe_o(wa_oe), .wave_out_b_o(wb_o), .wave_out_b_oe_o(wb_oe));
  // A 25 ns clock.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Prints the verdict and ends the run.
  task print_verdict;
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // Compares a value and reports a mismatch at once.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; the request stands until the rising edge at which ack is seen high.
  // Read data is taken and the request released at that same edge, so a next call idles one cycle.
  task wbx(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask : wbx
  // Reads a register and compares it.
  task rdc(input logic [11:0] a, input logic [31:0] e);
    wbx(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdc
  // Counts the cycles in which output A is high.
  task meas(input int n);
    hi = 0;
    repeat (n) begin
      @(negedge clk_i);
      if (wa === 1'b1) hi++;
    end
  endtask : meas
  // Sets a waveform mode at divide-by-one, lets it settle, then checks duty and pin ownership.
  task pwm(input logic [3:0] m, input logic [1:0] ca, input logic [1:0] cb, input logic [15:0] c,
           input int n, input int e, input logic oa, input logic ob);
    // Stop and clear the high mode bits first, so no write order ever passes through the reserved mode.
    wbx(1'b1, 12'h204, 32'h0);
    wbx(1'b1, 12'h200, {24'h0, ca, cb, 2'b00, m[1:0]});
    wbx(1'b1, 12'h204, {27'h0, m[3:2], 3'h1});
    wbx(1'b1, 12'h220, {16'h0, c});
    wbx(1'b1, 12'h22c, 32'h0);
    repeat (600) @(posedge clk_i);
    meas(n);
    if (e >= 0) chk(hi, e);
    chk({wa_oe, wb_oe}, {oa, ob});
  endtask : pwm
  // Cuts a hang short well after the expected run length.
  initial begin
    #(25 * 60000);
    num_errors++;
    print_verdict();
  end
  // Main sequence.
  initial begin
    num_errors = 0; n_checks = 0; rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h0;
    sel = 4'h0; dat = 32'h0; ext_pin = 1'b0; cap_pin = 1'b0; dir_a = 1'b1; dir_b = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(12'h200, 32'h0);
    rdc(12'h204, 32'h0);
    rdc(12'h3fc, 32'h0);
    wbx(1'b1, 12'h200, 32'hff);
    rdc(12'h200, 32'hf3);
    wbx(1'b1, 12'h204, 32'hff);
    rdc(12'h204, 32'hdf);
    wbx(1'b1, 12'h204, 32'h0);
    // Normal mode: set-on-match near the wrap, then overflow at the maximum count.
    wbx(1'b1, 12'h200, 32'hf0);
    wbx(1'b1, 12'h220, 32'hfff8);
    wbx(1'b1, 12'h22c, 32'hfff0);
    wbx(1'b1, 12'h230, 32'hf);
    wbx(1'b1, 12'h204, 32'h1);
    repeat (40) @(posedge clk_i);
    chk({wa, wa_oe, wb_o, wb_oe}, 4'hf);
    rdc(12'h230, 32'h7);
    dir_a <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(wa_oe, 1'b0);
    dir_a <= 1'b1;
    pwm(4'h4, 2'h1, 2'h0, 16'h003f, 512, 256, 1'b1, 1'b0);
    pwm(4'h5, 2'h2, 2'h0, 16'h0080, 512, 258, 1'b1, 1'b0);
    pwm(4'h5, 2'h3, 2'h0, 16'h0080, 512, 254, 1'b1, 1'b0);
    pwm(4'h5, 2'h2, 2'h0, 16'h00ff, 512, 512, 1'b1, 1'b0);
    pwm(4'h5, 2'h1, 2'h1, 16'h0080, 512, -1, 1'b0, 1'b0);
    pwm(4'hf, 2'h1, 2'h1, 16'h003f, 512, 256, 1'b1, 1'b0);
    pwm(4'h1, 2'h2, 2'h0, 16'h0080, 1020, 512, 1'b1, 1'b0);
    pwm(4'h1, 2'h3, 2'h0, 16'h0080, 1020, 508, 1'b1, 1'b0);
    pwm(4'h1, 2'h1, 2'h1, 16'h0080, 512, -1, 1'b0, 1'b0);
    pwm(4'hb, 2'h1, 2'h1, 16'h003f, 504, 252, 1'b1, 1'b0);
    // Stopped counter, filter on, rising edge: a short glitch is dropped, a steady level captures.
    wbx(1'b1, 12'h200, 32'h0);
    wbx(1'b1, 12'h204, 32'hc0);
    wbx(1'b1, 12'h22c, 32'h1234);
    wbx(1'b1, 12'h230, 32'hf);
    cap_pin <= 1'b1;
    repeat (3) @(posedge clk_i);
    cap_pin <= 1'b0;
    repeat (20) @(posedge clk_i);
    rdc(12'h230, 32'h0);
    cap_pin <= 1'b1;
    repeat (20) @(posedge clk_i);
    rdc(12'h230, 32'h8);
    rdc(12'h228, 32'h1234);
    // Capture register as TOP: a pin edge must not capture.
    wbx(1'b1, 12'h204, 32'h58);
    wbx(1'b1, 12'h230, 32'hf);
    cap_pin <= 1'b0;
    repeat (10) @(posedge clk_i);
    cap_pin <= 1'b1;
    repeat (20) @(posedge clk_i);
    rdc(12'h230, 32'h0);
    // External pin, rising edge: each pulse on the pin is one count.
    wbx(1'b1, 12'h204, 32'h7);
    wbx(1'b1, 12'h22c, 32'h0);
    repeat (5) begin
      ext_pin <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_pin <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    rdc(12'h22c, 32'h5);
    // Falling-edge capture with the filter off copies the count, held at 5 while the external clock pin idles.
    wbx(1'b1, 12'h230, 32'hf);
    cap_pin <= 1'b0;
    repeat (10) @(posedge clk_i);
    rdc(12'h230, 32'h8);
    rdc(12'h228, 32'h5);
    print_verdict();
  end
endmodule : tb_top
